// file: rtl/apcr_top.sv
// analogue power control bank: reference, bias and charge pump control
// assumes a strobe register port on core_clk and gain inputs on core_clk;
// the master clock presence flag comes from a pin and is synchronised here
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module apcr_top
    import apcr_pkg::*;
#(
    parameter int HOLD_CYC = RAIL_HOLD_CYC,
    parameter int LEVEL_W = GAIN_W
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // clocking configuration
    input wire logic core_clock_source,
    input wire logic mclk_present,
    input wire logic loop_locked,
    input wire logic loop_free_running,
    input wire logic [2:0] clock_ratio_code,
    // level inputs
    input wire apcr_gains_type gains,
    input wire logic [LEVEL_W-1:0] signal_level,
    // analogue controls
    output apcr_ctrl_type ctrl,
    output logic pump_clk,
    output logic pump_high_rail
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    initial
    begin
        if (HOLD_CYC < 1 || HOLD_CYC > 255)
            $error("rail hold count out of range");
        if (LEVEL_W != GAIN_W)
            $error("signal level width must match gain width");
        if (DIV_W < 5)
            $error("divider too narrow for the slowest pump ratio");
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // half period of the pump clock in core clock cycles
    function automatic logic [DIV_W-1:0] half_for_ratio(input logic [2:0] code);
        logic [DIV_W-1:0] h;
        h = 8'h10;
        case (code)
            3'h0: h = 8'h01;
            3'h1: h = 8'h02;
            3'h2: h = 8'h04;
            3'h3: h = 8'h08;
            default: h = 8'h10;
        endcase
        half_for_ratio = h;
    endfunction

    // ************************************************************
    // master clock presence synchroniser
    // ************************************************************
    // two stages; only the second one is read by the clock check, so a
    // metastable first stage never reaches the pump state machine
    logic mclk_meta_reg, mclk_meta_next;
    logic mclk_sync_reg, mclk_sync_next;

    always_comb
    begin
        mclk_meta_next = mclk_present;
        mclk_sync_next = mclk_meta_reg;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mclk_meta_reg <= 1'b0;
            mclk_sync_reg <= 1'b0;
        end
        else
        begin
            mclk_meta_reg <= mclk_meta_next;
            mclk_sync_reg <= mclk_sync_next;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    // writes to unmapped addresses or undefined bits are dropped
    apcr_ctrl_type ctrl_reg, ctrl_next;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (reg_wr)
        begin
            if (hit(reg_addr, OFS_BIAS_CONTROL))
                ctrl_next.bias_generator_enable = reg_wdata[POS_ENABLE];
            if (hit(reg_addr, OFS_REFERENCE_CONTROL))
            begin
                ctrl_next.reference_enable = reg_wdata[POS_ENABLE];
                ctrl_next.reference_divider_select =
                    apcr_div_type'(reg_wdata[POS_DIV_HI:POS_DIV_LO]);
            end
            if (hit(reg_addr, OFS_PUMP_CONTROL))
                ctrl_next.pump_enable = reg_wdata[POS_ENABLE];
            if (hit(reg_addr, OFS_PUMP_DYNAMIC_CONTROL))
                ctrl_next.pump_level_follows_signal = reg_wdata[POS_ENABLE];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg.reference_divider_select <= apcr_div_type'(RST_DIV_SEL);
            ctrl_reg.reference_enable <= RST_ENABLE;
            ctrl_reg.bias_generator_enable <= RST_ENABLE;
            ctrl_reg.pump_enable <= RST_ENABLE;
            ctrl_reg.pump_level_follows_signal <= RST_FOLLOW;
        end
        else
            ctrl_reg <= ctrl_next;
    end

    // the bias source needs the reference; software keeps that pairing
    // outputs follow software
    assign ctrl = ctrl_reg;

    // ************************************************************
    // pump clock availability
    // ************************************************************
    logic clock_ok;

    assign clock_ok = core_clock_source ? (loop_locked || loop_free_running)
                                        : mclk_sync_reg;

    // ************************************************************
    // pump state machine
    // ************************************************************
    // a lost clock drops back to waiting rather than running the pump on nothing
    apcr_pump_state_type state_reg, state_next;
    logic pump_run;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PUMP_OFF:
            begin
                if (ctrl_reg.pump_enable)
                    state_next = PUMP_WAIT_CLOCK;
            end
            PUMP_WAIT_CLOCK:
            begin
                if (!ctrl_reg.pump_enable)
                    state_next = PUMP_OFF;
                else if (clock_ok)
                    state_next = PUMP_RUN;
            end
            PUMP_RUN:
            begin
                if (!ctrl_reg.pump_enable)
                    state_next = PUMP_OFF;
                else if (!clock_ok)
                    state_next = PUMP_WAIT_CLOCK;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= PUMP_OFF;
        else
            state_reg <= state_next;
    end

    // clock held while disabled
    // enable gated in directly: the state machine alone would let the
    // clock run one edge longer after a disabling write
    assign pump_run = (state_reg == PUMP_RUN) && ctrl_reg.pump_enable;

    // ************************************************************
    // pump clock divider
    // ************************************************************
    logic [DIV_W-1:0] half_reg, half_next;

    // ratio is latched only while the pump is stopped, so a change of
    // clock settings never produces a runt pump clock phase
    always_comb
    begin
        half_next = half_reg;
        if (!pump_run)
            half_next = half_for_ratio(clock_ratio_code);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        // slowest ratio out of reset; while the pump is stopped the next edge reloads it from clock_ratio_code
        if (!rst_n)
            half_reg <= 8'h10;
        else
            half_reg <= half_next;
    end

    apcr_pump_clk_div #(
        .W(DIV_W)
    ) u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(pump_run),
        .half_count(half_reg),
        .pump_clk(pump_clk)
    );

    // ************************************************************
    // pump rail selection
    // ************************************************************
    // forcing the inputs to zero keeps the rail low while the pump is off
    logic want_high;
    apcr_gains_type gains_used;
    logic [5:0] level_used;

    assign gains_used = ctrl_reg.pump_enable ? gains : '0;
    assign level_used = ctrl_reg.pump_enable ? signal_level : '0;

    apcr_level_select u_sel (
        .follow_signal(ctrl_reg.pump_level_follows_signal),
        .gains(gains_used),
        .signal_level(level_used),
        .want_high(want_high)
    );

    // a rise in demand is served at once; a fall waits for the hold time
    // so the rail does not chatter on every signal peak
    logic high_reg, high_next;
    logic [7:0] hold_reg, hold_next;

    always_comb
    begin
        high_next = high_reg;
        hold_next = hold_reg;
        if (!ctrl_reg.pump_enable)
        begin
            high_next = 1'b0;
            hold_next = '0;
        end
        else if (want_high)
        begin
            high_next = 1'b1;
            hold_next = '0;
        end
        else if (high_reg)
        begin
            if (hold_reg >= 8'(HOLD_CYC - 1))
            begin
                high_next = 1'b0;
                hold_next = '0;
            end
            else
                hold_next = hold_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_reg <= 1'b0;
            hold_reg <= '0;
        end
        else
        begin
            high_reg <= high_next;
            hold_reg <= hold_next;
        end
    end

    assign pump_high_rail = high_reg;

    // ************************************************************
    // read back
    // ************************************************************
    // unmapped addresses and undefined bits read as zero; reads change nothing
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    always_comb
    begin
        rdata_next = '0;
        if (reg_rd)
        begin
            if (hit(reg_addr, OFS_BIAS_CONTROL))
                rdata_next[POS_ENABLE] = ctrl_reg.bias_generator_enable;
            if (hit(reg_addr, OFS_REFERENCE_CONTROL))
            begin
                rdata_next[POS_ENABLE] = ctrl_reg.reference_enable;
                rdata_next[POS_DIV_HI:POS_DIV_LO] = ctrl_reg.reference_divider_select;
            end
            if (hit(reg_addr, OFS_PUMP_CONTROL))
            begin
                rdata_next[POS_ENABLE] = ctrl_reg.pump_enable;
                rdata_next[POS_STAT_CLK] = pump_run;
                rdata_next[POS_STAT_HIGH] = high_reg;
            end
            if (hit(reg_addr, OFS_PUMP_DYNAMIC_CONTROL))
                rdata_next[POS_ENABLE] = ctrl_reg.pump_level_follows_signal;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

endmodule

// file: rtl/apcr_pkg.sv
// constants, carriers and state types for the analogue power control bank
// assumes a single 20 MHz core clock and a plain strobe register port
package apcr_pkg;

    // ************************************************************
    // register port and map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 9;
    localparam logic [7:0] OFS_BIAS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_REFERENCE_CONTROL = 8'h05;
    localparam logic [7:0] OFS_PUMP_CONTROL = 8'h62;
    localparam logic [7:0] OFS_PUMP_DYNAMIC_CONTROL = 8'h68;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int POS_ENABLE = 0;
    localparam int POS_DIV_LO = 1;
    localparam int POS_DIV_HI = 2;
    localparam int POS_STAT_CLK = 7;
    localparam int POS_STAT_HIGH = 8;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [1:0] RST_DIV_SEL = 2'h0;
    localparam logic RST_FOLLOW = 1'b0;

    // ************************************************************
    // gain fields and pump level threshold
    // ************************************************************
    localparam int GAIN_W = 6;
    localparam logic [5:0] GAIN_ZERO_DB = 6'h39;
    localparam logic [5:0] HIGH_RAIL_GAIN = 6'h33;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int RAIL_HOLD_NS = 1000;
    localparam int RAIL_HOLD_CYC = (RAIL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 8;

    typedef enum logic [1:0]
    {
        DIV_OFF,
        DIV_NORMAL,
        DIV_STANDBY,
        DIV_FAST_START
    } apcr_div_type;

    typedef enum
    {
        PUMP_OFF,
        PUMP_WAIT_CLOCK,
        PUMP_RUN
    } apcr_pump_state_type;

    typedef struct packed
    {
        apcr_div_type reference_divider_select;
        logic reference_enable;
        logic bias_generator_enable;
        logic pump_enable;
        logic pump_level_follows_signal;
    } apcr_ctrl_type;

    typedef struct packed
    {
        logic [5:0] hp_left_gain;
        logic [5:0] hp_right_gain;
        logic [5:0] line_left_gain;
        logic [5:0] line_right_gain;
    } apcr_gains_type;

endpackage

// file: rtl/apcr_pump_clk_div.sv
// pump clock divider: square wave at core clock over twice the half count
// assumes half_count is stable while run is high; run low parks output low
`timescale 1ns/100ps
module apcr_pump_clk_div
    import apcr_pkg::*;
#(
    parameter int W = DIV_W
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [W-1:0] half_count,
    // pump clock
    output logic pump_clk
);
    initial
    begin
        if (W < 2)
            $error("divider width too small");
    end

    logic [W-1:0] cnt_reg, cnt_next;
    logic clk_reg, clk_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        clk_next = clk_reg;
        if (!run)
        begin
            cnt_next = '0;
            clk_next = 1'b0;
        end
        else if (cnt_reg + W'(1) >= half_count)
        begin
            cnt_next = '0;
            clk_next = !clk_reg;
        end
        else
            cnt_next = cnt_reg + W'(1);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            clk_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
        end
    end

    assign pump_clk = clk_reg;
endmodule

// file: rtl/apcr_level_select.sv
// pump rail demand: highest of four gains, or live signal level
// assumes inputs come from logic on the core clock
`timescale 1ns/100ps
module apcr_level_select
    import apcr_pkg::*;
(
    // selection inputs
    input wire logic follow_signal,
    input wire apcr_gains_type gains,
    input wire logic [5:0] signal_level,
    // demand
    output logic want_high
);
    function automatic logic [5:0] max6(input logic [5:0] a, input logic [5:0] b);
        max6 = (a > b) ? a : b;
    endfunction

    logic [5:0] gain_peak;

    assign gain_peak = max6(max6(gains.hp_left_gain, gains.hp_right_gain),
                            max6(gains.line_left_gain, gains.line_right_gain));

    always_comb
    begin
        if (follow_signal)
            want_high = (signal_level >= HIGH_RAIL_GAIN);
        else
            want_high = (gain_peak >= HIGH_RAIL_GAIN);
    end
endmodule

// file: verification/apcr_top_asserts.sv
// port checker for the analogue power control bank
// assumes it is bound onto apcr_top and sees only its ports
`timescale 1ns/100ps
module apcr_top_asserts
    import apcr_pkg::*;
#(
    parameter int HOLD_CYC = RAIL_HOLD_CYC,
    parameter int LEVEL_W = GAIN_W
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // controls
    input wire apcr_ctrl_type ctrl,
    input wire logic pump_clk,
    input wire logic pump_high_rail
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // register writes
    // ************************************************************
    property p_ref_write;
        reg_wr && reg_addr == OFS_REFERENCE_CONTROL |=>
            ctrl.reference_enable == $past(reg_wdata[0]) &&
            ctrl.reference_divider_select == $past(reg_wdata[2:1]);
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("reference write lost");
    property p_bias_write;
        reg_wr && reg_addr == OFS_BIAS_CONTROL |=>
            ctrl.bias_generator_enable == $past(reg_wdata[0]);
    endproperty
    a_bias_write: assert property (p_bias_write) else $error("bias write lost");
    property p_pump_write;
        reg_wr && reg_addr == OFS_PUMP_CONTROL |=> ctrl.pump_enable == $past(reg_wdata[0]);
    endproperty
    a_pump_write: assert property (p_pump_write) else $error("pump write lost");
    property p_follow_stable;
        !(reg_wr && reg_addr == OFS_PUMP_DYNAMIC_CONTROL) |=>
            $stable(ctrl.pump_level_follows_signal);
    endproperty
    a_follow_stable: assert property (p_follow_stable) else $error("follow bit moved");

    // ************************************************************
    // register reads
    // ************************************************************
    property p_ref_read;
        reg_rd && reg_addr == OFS_REFERENCE_CONTROL |=> reg_rdata ==
            {6'h00, $past(ctrl.reference_divider_select), $past(ctrl.reference_enable)};
    endproperty
    a_ref_read: assert property (p_ref_read) else $error("reference readback wrong");
    property p_pump_read;
        reg_rd && reg_addr == OFS_PUMP_CONTROL |=>
            reg_rdata[0] == $past(ctrl.pump_enable) && reg_rdata[6:1] == 6'h00;
    endproperty
    a_pump_read: assert property (p_pump_read) else $error("pump readback wrong");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 9'h000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

    // ************************************************************
    // pump held off
    // ************************************************************
    // one cycle of grace: disable stops the clock on the following edge
    property p_pump_off;
        !ctrl.pump_enable && !$past(ctrl.pump_enable) |-> !pump_clk && !pump_high_rail;
    endproperty
    a_pump_off: assert property (p_pump_off) else $error("pump active while off");
endmodule

bind apcr_top apcr_top_asserts #(.HOLD_CYC(HOLD_CYC), .LEVEL_W(LEVEL_W)) chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ctrl(ctrl),
    .pump_clk(pump_clk),
    .pump_high_rail(pump_high_rail)
);

// file: verification/apcr_top_tb_top.sv
// self-checking bench for the analogue power control bank
// assumes apcr_top with a short rail hold; the bench drives every input
`timescale 1ns/100ps
module apcr_top_tb_top
    import apcr_pkg::*;
;
    localparam int HOLD = 2;
    localparam logic [7:0] OFS [4] = '{8'h04, 8'h05, 8'h62, 8'h68};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [8:0] reg_rdata;
    logic core_clock_source = 1'b0;
    logic mclk_present = 1'b0;
    logic loop_locked = 1'b0;
    logic loop_free_running = 1'b0;
    logic [2:0] clock_ratio_code = 3'h0;
    apcr_gains_type gains = '0;
    logic [5:0] signal_level = 6'h00;
    apcr_ctrl_type ctrl;
    logic pump_clk;
    logic pump_high_rail;
    logic [8:0] rd;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int half;
    int i;

    apcr_top #(.HOLD_CYC(HOLD), .LEVEL_W(6)) dut_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .core_clock_source(core_clock_source),
        .mclk_present(mclk_present),
        .loop_locked(loop_locked),
        .loop_free_running(loop_free_running),
        .clock_ratio_code(clock_ratio_code),
        .gains(gains),
        .signal_level(signal_level),
        .ctrl(ctrl),
        .pump_clk(pump_clk),
        .pump_high_rail(pump_high_rail)
    );

    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check_eq(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [8:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [8:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // reset values of every register, plus an unmapped hole
    task automatic do_reset();
        int k;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        check_eq(9'(ctrl), 9'h000);
        for (k = 0; k < 4; k++)
        begin
            reg_read(OFS[k], rd);
            check_eq(rd, 9'h000);
        end
        reg_read(8'h06, rd);
        check_eq(rd, 9'h000);
    endtask

    task automatic wait_run();
        int k;
        rd = 9'h000;
        for (k = 0; k < 20 && rd[7] !== 1'b1; k++)
            reg_read(OFS_PUMP_CONTROL, rd);
        check_eq(9'(rd[7]), 9'h001);
    endtask

    // cycles that one high phase of the pump clock lasts
    task automatic measure_half(output int n);
        int k;
        n = 0;
        for (k = 0; k < 40 && pump_clk !== 1'b0; k++)
            @(negedge core_clk);
        for (k = 0; k < 40 && pump_clk !== 1'b1; k++)
            @(negedge core_clk);
        while (n < 40 && pump_clk === 1'b1)
        begin
            @(negedge core_clk);
            n++;
        end
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        do_reset();
        for (i = 0; i < 8; i++)
        begin
            reg_write(OFS_REFERENCE_CONTROL, 9'h1F8 | 9'(i));
            check_eq(9'(ctrl[5:3]), 9'(i));
            reg_read(OFS_REFERENCE_CONTROL, rd);
            check_eq(rd, 9'(i));
        end
        reg_write(OFS_REFERENCE_CONTROL, 9'h003);
        check_eq(9'(ctrl[5:3]), 9'h003);
        reg_write(OFS_BIAS_CONTROL, 9'h1FF);
        reg_read(OFS_BIAS_CONTROL, rd);
        check_eq(rd, 9'h001);
        check_eq(9'(ctrl.bias_generator_enable), 9'h001);
        reg_write(OFS_PUMP_DYNAMIC_CONTROL, 9'h001);
        reg_read(OFS_PUMP_DYNAMIC_CONTROL, rd);
        check_eq(rd, 9'h001);
        // a second reset in mid-run must clear what was written
        do_reset();
        @(posedge core_clk);
        mclk_present <= 1'b1;
        for (i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            clock_ratio_code <= 3'(i);
            reg_write(OFS_PUMP_CONTROL, 9'h001);
            check_eq(9'(ctrl.pump_enable), 9'h001);
            wait_run();
            measure_half(half);
            check_eq(9'(half), i < 4 ? 9'(1 << i) : 9'h010);
            reg_write(OFS_PUMP_CONTROL, 9'h000);
        end
        @(posedge core_clk);
        gains <= {4{6'h3F}};
        signal_level <= 6'h3F;
        repeat (6) @(negedge core_clk);
        check_eq({7'h00, pump_clk, pump_high_rail}, 9'h000);
        @(posedge core_clk);
        clock_ratio_code <= 3'h0;
        reg_write(OFS_PUMP_CONTROL, 9'h001);
        wait_run();
        // gain mode: each field alone at the threshold, signal level ignored
        for (i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            gains <= {4{6'h32}} | (24'(6'h01) << (6 * i));
            repeat (3) @(negedge core_clk);
            check_eq(9'(pump_high_rail), 9'h001);
            @(posedge core_clk);
            gains <= {4{6'h32}};
            repeat (HOLD + 4) @(negedge core_clk);
            check_eq(9'(pump_high_rail), 9'h000);
        end
        reg_write(OFS_PUMP_DYNAMIC_CONTROL, 9'h001);
        @(posedge core_clk);
        gains <= {4{6'h3F}};
        signal_level <= 6'h32;
        repeat (HOLD + 4) @(negedge core_clk);
        check_eq(9'(pump_high_rail), 9'h000);
        @(posedge core_clk);
        signal_level <= 6'h33;
        repeat (3) @(negedge core_clk);
        check_eq(9'(pump_high_rail), 9'h001);
        reg_read(OFS_PUMP_CONTROL, rd);
        check_eq(rd, 9'h181);
        reg_write(OFS_PUMP_CONTROL, 9'h000);
        repeat (2) @(negedge core_clk);
        check_eq({7'h00, pump_clk, pump_high_rail}, 9'h000);
        // locked loop as source: no clock until the loop free-runs
        @(posedge core_clk);
        core_clock_source <= 1'b1;
        mclk_present <= 1'b0;
        reg_write(OFS_PUMP_CONTROL, 9'h001);
        repeat (10) @(negedge core_clk);
        reg_read(OFS_PUMP_CONTROL, rd);
        check_eq(9'(rd[7]), 9'h000);
        @(posedge core_clk);
        loop_free_running <= 1'b1;
        wait_run();
        measure_half(half);
        check_eq(9'(half), 9'h001);
        // locked output alone keeps the pump running; losing it stops the pump
        @(posedge core_clk);
        loop_free_running <= 1'b0;
        loop_locked <= 1'b1;
        repeat (10) @(negedge core_clk);
        reg_read(OFS_PUMP_CONTROL, rd);
        check_eq(rd, 9'h181);
        @(posedge core_clk);
        loop_locked <= 1'b0;
        repeat (4) @(negedge core_clk);
        check_eq(9'(pump_clk), 9'h000);
        reg_read(OFS_PUMP_CONTROL, rd);
        check_eq(rd, 9'h101);
        finish_test();
    end
endmodule
